// *** rtl/hpgs_defines.svh ***
// timing counts, register offsets and field positions of the power-good status block
`ifndef HPGS_DEFINES_SVH
`define HPGS_DEFINES_SVH

`define HPGS_CLK_MHZ       200
`define HPGS_TICK_US       1
`define HPGS_TICK_CYC      (`HPGS_CLK_MHZ * `HPGS_TICK_US)
`define HPGS_DLY_PG_MS     164
`define HPGS_SEP_MS        1
`define HPGS_DEB_MS        10
`define HPGS_STBY_LOW_NS   500
`define HPGS_STBY_LOW_CYC  ((`HPGS_STBY_LOW_NS * `HPGS_CLK_MHZ + 999) / 1000)

`define HPGS_DIV_W         8
`define HPGS_DLY_W         18
`define HPGS_SEP_W         10
`define HPGS_DEB_W         14
`define HPGS_LOW_W         7
`define HPGS_EVT_W         8

`define HPGS_ADDR_W        4
`define HPGS_OFF_STATUS    4'h0
`define HPGS_OFF_MASK      4'h4
`define HPGS_OFF_STATE     4'h8

`define HPGS_EV_MFAULT     0
`define HPGS_EV_SFAULT     2
`define HPGS_EV_DLYPG      4
`define HPGS_EV_CARD       6
`define HPGS_MASK_RST      8'h00

`endif

// *** rtl/hpgs_pkg.sv ***
// types shared by the power-good status block
`include "hpgs_defines.svh"

package hpgs_pkg;

  // per-slot power-good phase
  typedef enum logic [1:0] {PH_OFF, PH_WAIT, PH_GOOD, PH_DROP} hpgs_phase_t;

  typedef struct packed {
    logic [`HPGS_DIV_W-1:0]       div;
    logic                         tick;
    logic [1:0]                   men_q;
    logic [1:0]                   sen_q;
    hpgs_phase_t [1:0]            ph;
    logic [1:0][`HPGS_DLY_W-1:0]  dcnt;
    logic [1:0][`HPGS_SEP_W-1:0]  scnt;
    logic [1:0]                   fm;
    logic [1:0]                   fs;
    logic [1:0]                   em;
    logic [1:0]                   es;
    logic [1:0]                   arm;
    logic [1:0][`HPGS_LOW_W-1:0]  acnt;
    logic [1:0]                   card_q;
    logic [1:0]                   pg_oe;
    logic [1:0]                   dly_oe;
    logic [1:0]                   fm_oe;
    logic [1:0]                   fs_oe;
    logic                         sys_oe;
    logic                         int_oe;
    logic [`HPGS_EVT_W-1:0]       sts;
    logic [`HPGS_EVT_W-1:0]       msk;
    logic [31:0]                  rdata;
  } hpgs_state_t;

endpackage

// *** rtl/hpgs_filt.sv ***
// pin synchroniser with optional per-bit stability filter
`timescale 1ns/1ps
`default_nettype none

module hpgs_filt
#(
  parameter int           W      = 2,
  parameter int           STABLE = 0,
  parameter int           CW     = 4,
  parameter logic [W-1:0] INIT   = '0
)
(
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         tick,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0]         s1;
    logic [W-1:0]         s2;
    logic [W-1:0]         out;
    logic [W-1:0][CW-1:0] cnt;
  } hpgs_filt_t;

  localparam logic [CW-1:0] LAST = CW'((STABLE > 0) ? STABLE - 1 : 0);

  hpgs_filt_t st_r;
  hpgs_filt_t st_nxt;

  // a bit moves to the output only after staying put for STABLE ticks
  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    for (int i = 0; i < W; i++)
    begin
      if (st_r.s2[i] == st_r.out[i])
      begin
        st_nxt.cnt[i] = '0;
      end
      else if (STABLE == 0)
      begin
        st_nxt.out[i] = st_r.s2[i];
      end
      else if (tick)
      begin
        if (st_r.cnt[i] == LAST)
        begin
          st_nxt.out[i] = st_r.s2[i];
          st_nxt.cnt[i] = '0;
        end
        else
        begin
          st_nxt.cnt[i] = st_r.cnt[i] + 1'b1;
        end
      end
    end
  end

  // synchronous active-low reset
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      st_r     <= '0;
      st_r.s1  <= INIT;
      st_r.s2  <= INIT;
      st_r.out <= INIT;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.out;

endmodule // hpgs_filt

`default_nettype wire

// *** rtl/hpgs_top.sv ***
// dual-slot power-good, delayed power-good, system power-good and fault interrupt logic
//
// Behaviour
// - delayed power-good asserts 164 ms after power-good
// - delayed power-good drops with slot power-good
// - enable falling edge releases delayed power-good
// - delayed and plain power-good drop 1 ms apart
// - slot A main rail low pulls system good
// - slot B main rail low pulls system good
// - slot A standby rail low pulls system good
// - slot B standby rail low pulls system good
// - otherwise system power-good stays released
// - any rail fault drives interrupt low
// - interrupt clears with the fault-clearing enable toggle
// - standby fault clears after 0.5 us low enable
// - dual faults need both enable edges to clear
// - override asserts good outputs, releases fault lines
// - card-present input debounced for 10 ms
`timescale 1ns/1ps
`default_nettype none
`include "hpgs_defines.svh"

module hpgs_top
#(
  parameter int DLY_TICKS = `HPGS_DLY_PG_MS * 1000 / `HPGS_TICK_US,
  parameter int SEP_TICKS = `HPGS_SEP_MS * 1000 / `HPGS_TICK_US,
  parameter int DEB_TICKS = `HPGS_DEB_MS * 1000 / `HPGS_TICK_US
)
(
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  input  wire logic [1:0]                 main_enable,
  input  wire logic [1:0]                 standby_enable,
  input  wire logic [1:0]                 card_present_n,
  input  wire logic [1:0]                 override_n,
  input  wire logic [1:0]                 main12_good,
  input  wire logic [1:0]                 main3_good,
  input  wire logic [1:0]                 standby_rail_good,
  input  wire logic [1:0]                 main_fault_det,
  input  wire logic [1:0]                 standby_fault_det,
  output logic      [1:0]                 slot_power_good_n_oe,
  output logic      [1:0]                 delayed_power_good_n_oe,
  output logic                            system_power_good_oe,
  output logic                            int_n_oe,
  output logic      [1:0]                 main_fault_n_oe,
  output logic      [1:0]                 standby_fault_n_oe,
  input  wire logic [`HPGS_ADDR_W-1:0]    reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  output logic                            irq
);
  import hpgs_pkg::*;

  localparam logic [`HPGS_DIV_W-1:0] DIV_LAST = `HPGS_DIV_W'(`HPGS_TICK_CYC - 1);
  localparam logic [`HPGS_DLY_W-1:0] DLY_LAST = `HPGS_DLY_W'(DLY_TICKS - 1);
  localparam logic [`HPGS_SEP_W-1:0] SEP_LAST = `HPGS_SEP_W'(SEP_TICKS - 1);
  localparam logic [`HPGS_LOW_W-1:0] LOW_LAST = `HPGS_LOW_W'(`HPGS_STBY_LOW_CYC - 1);
  localparam int                     PIN_W    = 18;

  hpgs_state_t st_r;
  hpgs_state_t st_nxt;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s;
  logic [1:0]       card_n_db;

  // plain level pins: three-flop synchronisers only
  assign pin_raw = {main_enable, standby_enable, override_n, main12_good, main3_good,
                    standby_rail_good, main_fault_det, standby_fault_det, 2'h0};

  hpgs_filt
  #(
    .W      (PIN_W),
    .STABLE (0),
    .CW     (1),
    .INIT   (18'h03000)   // override_n idles high, so no false override after reset
  )
  u_pin_sync
  (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .tick    (st_r.tick),
    .din     (pin_raw),
    .dout    (pin_s)
  );

  // card-present: synchronised, then held stable before it counts
  hpgs_filt
  #(
    .W      (2),
    .STABLE (DEB_TICKS),
    .CW     (`HPGS_DEB_W),
    .INIT   (2'h3)
  )
  u_card_deb
  (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .tick    (st_r.tick),
    .din     (card_present_n),
    .dout    (card_n_db)
  );

  logic [1:0] men;
  logic [1:0] sen;
  logic [1:0] ovr;
  logic [1:0] r12;
  logic [1:0] r3;
  logic [1:0] rs;
  logic [1:0] mdet;
  logic [1:0] sdet;
  logic [1:0] card;

  // unpack the synchronised pins
  assign men  = pin_s[17:16];
  assign sen  = pin_s[15:14];
  assign ovr  = ~pin_s[13:12];
  assign r12  = pin_s[11:10];
  assign r3   = pin_s[9:8];
  assign rs   = pin_s[7:6];
  assign mdet = pin_s[5:4];
  assign sdet = pin_s[3:2];
  assign card = ~card_n_db;

  logic                   wr_sts;
  logic                   wr_msk;
  logic [`HPGS_EVT_W-1:0] ev;
  logic [`HPGS_EVT_W-1:0] w1c;

  // register write decode
  assign wr_sts = reg_wr && (reg_addr == `HPGS_OFF_STATUS);
  assign wr_msk = reg_wr && (reg_addr == `HPGS_OFF_MASK);
  assign w1c    = wr_sts ? reg_wdata[`HPGS_EVT_W-1:0] : '0;

  always_comb
  begin
    logic [1:0] want;
    logic [1:0] m_fall;
    logic [1:0] s_fall;
    logic [1:0] s_ok;
    logic [1:0] both;
    logic [1:0] clr2;
    logic [1:0] fm_set;
    logic [1:0] fs_set;
    logic [1:0] sys_low;
    logic [1:0] pg_on;
    logic [1:0] dly_on;
    want    = '0;
    m_fall  = '0;
    s_fall  = '0;
    s_ok    = '0;
    both    = '0;
    clr2    = '0;
    fm_set  = '0;
    fs_set  = '0;
    sys_low = '0;
    pg_on   = '0;
    dly_on  = '0;
    ev      = '0;
    st_nxt  = st_r;

    // free-running microsecond timebase
    st_nxt.tick = 1'b0;
    if (st_r.div == DIV_LAST)
    begin
      st_nxt.div  = '0;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.div = st_r.div + 1'b1;
    end

    st_nxt.men_q  = men;
    st_nxt.sen_q  = sen;
    st_nxt.card_q = card;
    m_fall        = st_r.men_q & ~men;
    s_fall        = st_r.sen_q & ~sen;

    for (int s = 0; s < 2; s++)
    begin
      // slot power is good with a seated card, main on, rails up, no latched main fault
      want[s] = ovr[s] | (card[s] & men[s] & r12[s] & r3[s] & ~st_r.fm[s]);

      // phase walk: off, counting, delayed good, dropping
      unique case (st_r.ph[s])
        PH_OFF:
        begin
          st_nxt.dcnt[s] = '0;
          if (want[s])
          begin
            st_nxt.ph[s] = PH_WAIT;
          end
        end
        PH_WAIT:
        begin
          if (!want[s])
          begin
            st_nxt.ph[s]   = PH_DROP;
            st_nxt.scnt[s] = '0;
            st_nxt.dcnt[s] = '0;
          end
          else if (m_fall[s] || s_fall[s])
          begin
            st_nxt.dcnt[s] = '0;
          end
          else if (st_r.tick)
          begin
            if (st_r.dcnt[s] == DLY_LAST)
            begin
              st_nxt.ph[s] = PH_GOOD;
              ev[`HPGS_EV_DLYPG + s] = 1'b1;
            end
            else
            begin
              st_nxt.dcnt[s] = st_r.dcnt[s] + 1'b1;
            end
          end
        end
        PH_GOOD:
        begin
          st_nxt.dcnt[s] = '0;
          if (!want[s])
          begin
            st_nxt.ph[s]   = PH_DROP;
            st_nxt.scnt[s] = '0;
          end
          else if (m_fall[s] || s_fall[s])
          begin
            st_nxt.ph[s] = PH_WAIT;
          end
        end
        PH_DROP:
        begin
          // delayed output already released; plain output held one more interval
          if (want[s])
          begin
            st_nxt.ph[s]   = PH_WAIT;
            st_nxt.dcnt[s] = '0;
          end
          else if (st_r.tick)
          begin
            if (st_r.scnt[s] == SEP_LAST)
            begin
              st_nxt.ph[s] = PH_OFF;
            end
            else
            begin
              st_nxt.scnt[s] = st_r.scnt[s] + 1'b1;
            end
          end
        end
      endcase

      // standby enable must stay low long enough to count as a clear
      if (s_fall[s])
      begin
        st_nxt.arm[s]  = 1'b1;
        st_nxt.acnt[s] = '0;
      end
      else if (!sen[s])
      begin
        if (st_r.arm[s] && st_r.acnt[s] == LOW_LAST)
        begin
          s_ok[s]       = 1'b1;
          st_nxt.arm[s] = 1'b0;
        end
        else if (st_r.arm[s])
        begin
          st_nxt.acnt[s] = st_r.acnt[s] + 1'b1;
        end
      end
      else
      begin
        st_nxt.arm[s] = 1'b0;
      end

      // fault latches; detection wins over a clear in the same cycle
      fm_set[s]    = mdet[s] & ~ovr[s];
      fs_set[s]    = sdet[s] & ~ovr[s];
      both[s]      = st_r.fm[s] & st_r.fs[s];
      st_nxt.em[s] = both[s] & (st_r.em[s] | m_fall[s]);
      st_nxt.es[s] = both[s] & (st_r.es[s] | s_ok[s]);
      clr2[s]      = both[s] & (st_r.em[s] | m_fall[s]) & (st_r.es[s] | s_ok[s]);
      if (both[s])
      begin
        st_nxt.fm[s] = fm_set[s] | (st_r.fm[s] & ~clr2[s]);
        st_nxt.fs[s] = fs_set[s] | (st_r.fs[s] & ~clr2[s]);
      end
      else
      begin
        st_nxt.fm[s] = fm_set[s] | (st_r.fm[s] & ~m_fall[s]);
        st_nxt.fs[s] = fs_set[s] | (st_r.fs[s] & ~s_ok[s]);
      end
      ev[`HPGS_EV_MFAULT + s] = fm_set[s] & ~st_r.fm[s];
      ev[`HPGS_EV_SFAULT + s] = fs_set[s] & ~st_r.fs[s];
      ev[`HPGS_EV_CARD + s]   = card[s] ^ st_r.card_q[s];
    end

    // system power-good pull-down terms, one per rail group
    sys_low[0] = card[0] & men[0] & ~ovr[0] & ~(r12[0] & r3[0]);
    sys_low[1] = card[1] & men[1] & ~ovr[1] & ~(r12[1] & r3[1]);
    for (int s = 0; s < 2; s++)
    begin
      pg_on[s]  = (st_nxt.ph[s] != PH_OFF) | ovr[s];
      dly_on[s] = (st_nxt.ph[s] == PH_GOOD) | ovr[s];
    end

    // open-drain enables, registered so the pins never glitch
    st_nxt.pg_oe  = pg_on;
    st_nxt.dly_oe = dly_on;
    st_nxt.fm_oe  = st_nxt.fm & ~ovr;
    st_nxt.fs_oe  = st_nxt.fs & ~ovr;
    st_nxt.sys_oe = (|sys_low)
                  | (card[0] & sen[0] & ~ovr[0] & ~rs[0])
                  | (card[1] & sen[1] & ~ovr[1] & ~rs[1]);
    st_nxt.int_oe = |((st_nxt.fm | st_nxt.fs) & ~ovr);

    // sticky status, write-one-to-clear, a new event beats the clear
    st_nxt.sts = (st_r.sts & ~w1c) | ev;
    if (wr_msk)
    begin
      st_nxt.msk = reg_wdata[`HPGS_EVT_W-1:0];
    end

    // read data valid in the cycle after the strobe only
    st_nxt.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `HPGS_OFF_STATUS: st_nxt.rdata = {24'h000000, st_r.sts};
        `HPGS_OFF_MASK:   st_nxt.rdata = {24'h000000, st_r.msk};
        `HPGS_OFF_STATE:  st_nxt.rdata = {20'h00000, st_r.int_oe, ~st_r.sys_oe,
                                          st_r.card_q, st_r.fs, st_r.fm,
                                          st_r.dly_oe, st_r.pg_oe};
        default:          st_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  // synchronous active-low reset; everything released, mask closed
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      st_r     <= '0;
      st_r.msk <= `HPGS_MASK_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign slot_power_good_n_oe    = st_r.pg_oe;
  assign delayed_power_good_n_oe = st_r.dly_oe;
  assign system_power_good_oe    = st_r.sys_oe;
  assign int_n_oe                = st_r.int_oe;
  assign main_fault_n_oe         = st_r.fm_oe;
  assign standby_fault_n_oe      = st_r.fs_oe;
  assign reg_rdata               = st_r.rdata;
  assign irq                     = |(st_r.sts & st_r.msk);

endmodule // hpgs_top

`default_nettype wire

// *** verification/hpgs_host_model.sv ***
// host hot-plug logic and rail supplies facing the status block
`timescale 1ns/1ps
`default_nettype none

module hpgs_host_model
(
  input  wire logic [3:0] sag,
  input  wire logic       ref_clk,
  input  wire logic [1:0] pg_oe,
  input  wire logic [1:0] dly_oe,
  output logic      [1:0] main_enable,
  output logic      [1:0] standby_enable,
  output logic      [1:0] main12_good,
  output logic      [1:0] main3_good,
  output logic      [1:0] standby_rail_good,
  output logic      [1:0] pg_pin,
  output logic      [1:0] dly_pin
);
  // everything off and unpowered at time zero
  initial
  begin
    main_enable       = 2'h0;
    standby_enable    = 2'h0;
    main12_good       = 2'h0;
    main3_good        = 2'h0;
    standby_rail_good = 2'h0;
  end

  // rails follow their enables a cycle later; sag is the only commanded misbehaviour
  always @(posedge ref_clk)
  begin
    main12_good       <= main_enable & ~sag[1:0];
    main3_good        <= main_enable & ~sag[1:0];
    standby_rail_good <= standby_enable & ~sag[3:2];
  end

  // open-drain lines with pull-ups, so a released line reads high
  assign pg_pin  = ~pg_oe;
  assign dly_pin = ~dly_oe;

  task automatic set_en(input int s, input logic m, input logic sb);
    @(posedge ref_clk);
    main_enable[s]    <= m;
    standby_enable[s] <= sb;
  endtask

  // fault clearing: selected enables fall and stay low past the standby minimum
  task automatic pulse(input int s, input logic m, input logic sb);
    @(posedge ref_clk);
    if (m)
      main_enable[s] <= 1'b0;
    if (sb)
      standby_enable[s] <= 1'b0;
    repeat (120) @(posedge ref_clk);
    main_enable[s]    <= 1'b1;
    standby_enable[s] <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule // hpgs_host_model

`default_nettype wire

// *** verification/hpgs_top_checker.sv ***
// concurrent checks on the ports of the power-good status block
`timescale 1ns/1ps
`default_nettype none
`include "hpgs_defines.svh"

module hpgs_top_checker
#(
  parameter int DLY_TICKS = 164000,
  parameter int SEP_TICKS = 1000
)
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic [1:0]  standby_enable,
  input wire logic [1:0]  override_n,
  input wire logic [1:0]  main12_good,
  input wire logic [1:0]  main3_good,
  input wire logic [1:0]  standby_rail_good,
  input wire logic [1:0]  slot_power_good_n_oe,
  input wire logic [1:0]  delayed_power_good_n_oe,
  input wire logic        system_power_good_oe,
  input wire logic        int_n_oe,
  input wire logic [1:0]  main_fault_n_oe,
  input wire logic [1:0]  standby_fault_n_oe,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata
);
  // one tick of slack, the timebase phase is unknown to the host
  localparam int LO_DLY = (DLY_TICKS - 1) * `HPGS_TICK_CYC;
  localparam int LO_SEP = (SEP_TICKS - 1) * `HPGS_TICK_CYC;
  logic [31:0] pg_cnt_r;
  logic [31:0] gap_cnt_r;
  logic [5:0]  bad_r;

  // slot A good time, time since its delayed good dropped, rail-low history
  always_ff @(posedge ref_clk)
  begin
    pg_cnt_r  <= slot_power_good_n_oe[0] ? pg_cnt_r + 32'h1 : 32'h0;
    gap_cnt_r <= (delayed_power_good_n_oe[0] || !nrst) ? 32'h0 : gap_cnt_r + 32'h1;
    bad_r     <= {bad_r[4:0], {main12_good, main3_good, standby_rail_good} != 6'h3F};
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  dly_delay_a: assert property ($rose(delayed_power_good_n_oe[0]) && override_n[0]
    |-> pg_cnt_r >= LO_DLY) else $error("delayed good asserted too early");
  dly_with_pg_a: assert property (delayed_power_good_n_oe[0] |-> slot_power_good_n_oe[0])
    else $error("delayed good without power good");
  en_fall_a: assert property ($fell(standby_enable[0]) && override_n[0]
    |-> ##[1:6] !delayed_power_good_n_oe[0]) else $error("enable fall kept delayed good");
  drop_gap_a: assert property ($fell(slot_power_good_n_oe[0]) && override_n[0]
    |-> gap_cnt_r >= LO_SEP) else $error("power good dropped too soon");
  sys_cause_a: assert property (system_power_good_oe |-> |bad_r)
    else $error("system good pulled with all rails good");
  int_fault_a: assert property ($rose(|{main_fault_n_oe, standby_fault_n_oe})
    |-> ##[0:2] int_n_oe) else $error("fault without interrupt");
  int_cause_a: assert property (int_n_oe |-> (|{main_fault_n_oe, standby_fault_n_oe,
    $past(main_fault_n_oe), $past(standby_fault_n_oe)}) or ##1 (|main_fault_n_oe))
    else $error("interrupt without fault");
  ovr_force_a: assert property ((!override_n[1]) [*8] |-> slot_power_good_n_oe[1]
    && delayed_power_good_n_oe[1] && !main_fault_n_oe[1] && !standby_fault_n_oe[1])
    else $error("override not honoured");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");

  cover property ($rose(delayed_power_good_n_oe[0]));
  cover property ($fell(slot_power_good_n_oe[0]));
  cover property ($rose(int_n_oe));
endmodule // hpgs_top_checker

bind hpgs_top hpgs_top_checker #(.DLY_TICKS(DLY_TICKS), .SEP_TICKS(SEP_TICKS)) u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .standby_enable(standby_enable),
  .override_n(override_n), .main12_good(main12_good), .main3_good(main3_good),
  .standby_rail_good(standby_rail_good), .slot_power_good_n_oe(slot_power_good_n_oe),
  .delayed_power_good_n_oe(delayed_power_good_n_oe),
  .system_power_good_oe(system_power_good_oe), .int_n_oe(int_n_oe),
  .main_fault_n_oe(main_fault_n_oe), .standby_fault_n_oe(standby_fault_n_oe),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata));

`default_nettype wire

// *** verification/test_hpgs_top.sv ***
// self-checking bench of the power-good status block
`timescale 1ns/1ps
`default_nettype none
`include "hpgs_defines.svh"

module test_hpgs_top;
  localparam int DLY = 20;
  localparam int SEP = 5;
  localparam int TC  = `HPGS_TICK_CYC;
  logic            ref_clk = 1'b0;
  logic            nrst = 1'b0;
  logic [1:0]      card_present_n = 2'h3;
  logic [1:0]      override_n = 2'h3;
  logic [1:0]      mf_det = 2'h0;
  logic [1:0]      sf_det = 2'h0;
  logic [3:0]      sag = 4'h0;
  logic [3:0]      reg_addr = 4'h0;
  logic [31:0]     reg_wdata = 32'h0;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  wire logic [1:0] men, sen, g12, g3, gsb, pg_oe, dly_oe, mf_oe, sf_oe, pg_pin, dly_pin;
  wire logic       sys_oe, int_oe, irq;
  wire logic [31:0] rdata;
  wire logic [5:0] obs = {int_oe, sys_oe, dly_oe, pg_oe};
  logic [31:0]     d;
  int              n;
  int              cyc = 0;
  int              fail_count = 0;
  int              n_checks = 0;

  // 200 MHz
  always #2.5 ref_clk = ~ref_clk;

  hpgs_top #(.DLY_TICKS(DLY), .SEP_TICKS(SEP), .DEB_TICKS(3)) DUT (
    .ref_clk(ref_clk), .nrst(nrst), .main_enable(men), .standby_enable(sen),
    .card_present_n(card_present_n), .override_n(override_n), .main12_good(g12),
    .main3_good(g3), .standby_rail_good(gsb), .main_fault_det(mf_det),
    .standby_fault_det(sf_det), .slot_power_good_n_oe(pg_oe),
    .delayed_power_good_n_oe(dly_oe), .system_power_good_oe(sys_oe), .int_n_oe(int_oe),
    .main_fault_n_oe(mf_oe), .standby_fault_n_oe(sf_oe), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .irq(irq));

  hpgs_host_model host (.ref_clk(ref_clk), .sag(sag), .pg_oe(pg_oe), .dly_oe(dly_oe),
    .main_enable(men), .standby_enable(sen), .main12_good(g12), .main3_good(g3),
    .standby_rail_good(gsb), .pg_pin(pg_pin), .dly_pin(dly_pin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data is only valid in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = rdata;
  endtask

  // bounded wait on one observed line, sampled after the edge settles
  task automatic wait_bit(input int b, input logic v, input int lim);
    #1 n = 0;
    while (obs[b] !== v && n < lim)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(obs[b], v);
  endtask

  task automatic t_sys;
    int i;
    host.set_en(0, 1'b1, 1'b1);
    host.set_en(1, 1'b1, 1'b1);
    // enables reach the logic a cycle before the rails; let that blip pass first
    repeat (20) @(posedge ref_clk);
    wait_bit(4, 1'b0, 0);
    for (i = 0; i < 4; i++)
    begin
      sag <= 4'h1 << i;
      wait_bit(4, 1'b1, 10);
      sag <= 4'h0;
      wait_bit(4, 1'b0, 10);
    end
  endtask

  // a drop halfway through the interval must restart it
  task automatic t_delay;
    wait_bit(0, 1'b1, 2000);
    repeat (2000) @(posedge ref_clk);
    sag <= 4'h1;
    wait_bit(0, 1'b0, 2000);
    sag <= 4'h0;
    wait_bit(0, 1'b1, 20);
    wait_bit(2, 1'b1, 6000);
    chk(n >= (DLY - 1) * TC && n <= (DLY + 1) * TC, 1'b1);
    chk(dly_pin[0], 1'b0);
  endtask

  task automatic t_drop;
    sag <= 4'h1;
    wait_bit(2, 1'b0, 20);
    chk(pg_pin[0], 1'b0);
    wait_bit(0, 1'b0, 2000);
    chk(n >= (SEP - 1) * TC && n <= (SEP + 1) * TC, 1'b1);
    sag <= 4'h0;
  endtask

  task automatic t_en;
    wait_bit(2, 1'b1, 6000);
    host.set_en(0, 1'b1, 1'b0);
    wait_bit(2, 1'b0, 10);
    chk(pg_oe[0], 1'b1);
    host.set_en(0, 1'b1, 1'b1);
  endtask

  task automatic t_fault;
    wr(4'h4, 32'h2);
    mf_det <= 2'h2;
    @(posedge ref_clk);
    mf_det <= 2'h0;
    wait_bit(5, 1'b1, 10);
    chk(mf_oe, 2'h2);
    chk(irq, 1'b1);
    rd(4'h0);
    chk(d[1], 1'b1);
    wr(4'h0, 32'h2);
    sf_det <= 2'h2;
    @(posedge ref_clk);
    sf_det <= 2'h0;
    repeat (8) @(posedge ref_clk);
    #1 chk(irq, 1'b0);
    chk(sf_oe, 2'h2);
    host.pulse(1, 1'b1, 1'b0);
    wait_bit(5, 1'b1, 0);
    chk({mf_oe, sf_oe}, 4'hA);
    host.pulse(1, 1'b1, 1'b1);
    wait_bit(5, 1'b0, 20);
    chk({mf_oe, sf_oe}, 4'h0);
    rd(4'hC);
    chk(d, 32'h0);
  endtask

  task automatic t_ovr;
    @(posedge ref_clk);
    mf_det <= 2'h2;
    @(posedge ref_clk);
    mf_det <= 2'h0;
    wait_bit(5, 1'b1, 10);
    @(posedge ref_clk);
    override_n <= 2'h1;
    wait_bit(5, 1'b0, 10);
    wait_bit(3, 1'b1, 10);
    chk({pg_oe[1], mf_oe[1], sys_oe}, 3'h4);
    @(posedge ref_clk);
    override_n <= 2'h3;
    host.pulse(1, 1'b1, 1'b1);
    wait_bit(5, 1'b0, 20);
  endtask

  task automatic final_report;
    $display("checks=%0d errors=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, well above the expected run of about 13500 cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      final_report;
    end
  end

  // reset, let the card debounce settle, then the scenarios
  initial
  begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    card_present_n <= 2'h0;
    // card must not count until it has stayed seated for the debounce time
    rd(4'h8);
    chk(d[9:8], 2'h0);
    repeat (1000) @(posedge ref_clk);
    rd(4'h8);
    chk(d[9:8], 2'h3);
    t_sys;
    t_delay;
    t_drop;
    t_en;
    t_fault;
    t_ovr;
    final_report;
  end
endmodule // test_hpgs_top

`default_nettype wire
